// >>> inc/tci_pkg.sv
// tci_pkg: offsets, reset values, field layout, timings and types of the
// touch calibration and interrupt register bank.
// assumes a 200 MHz clock and a register port fed by the serial interface.
package tci_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] ADDR_GROUP_TIMING = 8'h24;
    localparam logic [7:0] ADDR_AUTO_CAL_EN = 8'h25;
    localparam logic [7:0] ADDR_CAL_REQUEST = 8'h26;
    localparam logic [7:0] ADDR_TOUCH_IRQ_EN = 8'h27;
    localparam logic [7:0] ADDR_GPIO_IRQ_EN = 8'h28;
    localparam logic [7:0] ADDR_GROUP_CAL_REQ = 8'h46;

    // reset values
    localparam logic [7:0] RST_GROUP_TIMING = 8'hd4;
    localparam logic [7:0] RST_AUTO_CAL_EN = 8'hff;
    localparam logic [7:0] RST_CAL_REQUEST = 8'h00;
    localparam logic [7:0] RST_TOUCH_IRQ_EN = 8'hff;
    localparam logic [7:0] RST_GPIO_IRQ_EN = 8'h00;
    localparam logic [6:0] RST_GROUP_CAL_REQ = 7'h00;

    // field positions
    localparam int TIMEOUT_MSB = 7;
    localparam int TIMEOUT_LSB = 4;
    localparam int REPEAT_MSB = 3;
    localparam int REPEAT_LSB = 0;
    localparam int GROUP_BIT = 7;
    localparam int NUM_SINGLE = 7;
    localparam int NUM_GROUPED = 7;
    localparam int NUM_SENSORS = 14;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int MS_PS = 1000000000;
    localparam int MS_CYCLES = MS_PS / CLK_PERIOD_PS;
    localparam logic [13:0] CAL_WINDOW_MS = 14'd600;
    localparam logic [13:0] REPEAT_STEP_MS = 14'd35;

    // press timeout code to milliseconds
    function automatic logic [13:0] press_timeout_ms(input logic [3:0] code);
        case (code)
            4'h0: press_timeout_ms = 14'd560;
            4'h1: press_timeout_ms = 14'd840;
            4'h2: press_timeout_ms = 14'd1120;
            4'h3: press_timeout_ms = 14'd1400;
            4'h4: press_timeout_ms = 14'd1680;
            4'h5: press_timeout_ms = 14'd2240;
            4'h6: press_timeout_ms = 14'd2800;
            4'h7: press_timeout_ms = 14'd3360;
            4'h8: press_timeout_ms = 14'd3920;
            4'h9: press_timeout_ms = 14'd4480;
            4'ha: press_timeout_ms = 14'd5600;
            4'hb: press_timeout_ms = 14'd6720;
            4'hc: press_timeout_ms = 14'd7840;
            4'hd: press_timeout_ms = 14'd8906;
            4'he: press_timeout_ms = 14'd10080;
            default: press_timeout_ms = 14'd11200;
        endcase
    endfunction : press_timeout_ms

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {CAL_IDLE, CAL_ANALOG, CAL_DIGITAL} tci_cal_state_type;

    typedef struct packed {
        logic [NUM_SENSORS-1:0] mask;
        logic analog_start;
        logic digital_start;
        logic busy;
    } tci_cal_out_type;

    typedef struct packed {
        logic [7:0] group_timing;
        logic [7:0] auto_cal_en;
        logic [7:0] cal_request;
        logic [7:0] touch_irq_en;
        logic [7:0] gpio_irq_en;
        logic [6:0] group_cal_req;
        logic [7:0] rdata;
        logic irq;
        logic [31:0] ms_div;
        logic [13:0] press_ms;
        logic press_done;
        logic [13:0] repeat_ms;
        logic repeat_pulse;
        logic [NUM_SENSORS-1:0] auto_pend;
        tci_cal_state_type cal_state;
        logic [13:0] cal_ms;
        logic group_in_run;
        logic [NUM_SENSORS-1:0] cal_fail;
        tci_cal_out_type cal;
    } tci_state_type;

endpackage : tci_pkg

// >>> rtl/tci_regs.sv
// tci_regs: calibration, timing and interrupt enable registers with the
// recalibration sequencer and interrupt pin gating.
// assumes the serial interface decodes transfers into one-cycle read and
// write strobes, and the sensing engine runs on the same clock.
//
// Contract
// - group timing register 24h resets d4h
// - press timeout code maps nonlinear 560..11200ms
// - low nibble sets slide repeat interval
// - repeat interval is (code+1) times 35ms
// - auto calibration enables 25h reset ffh
// - auto enable ignored for unsampled sensors
// - group auto off: only manual group recal
// - request bit starts recal, self-clears when done
// - group request clears after whole group succeeds
// - 46h holds grouped sensor requests, bit7 unused
// - recal runs analog update then digital capture
// - recal blanks presses, base counts invalid, 600ms
// - touch during recal invalidates the attempt
// - 27h bit7 gates group gesture interrupts
// - 27h bits 6..0 gate sensor touch interrupts
// - 28h resets 00h, gates gpio interrupts
// - enabled gpio status asserts interrupt pin
`timescale 1ns/1ps

module tci_regs
    import tci_pkg::*;
#(
    parameter int ms_cycles = MS_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] sample_enable,
    input wire logic [6:0] group_sample_enable,
    input wire logic [NUM_SENSORS-1:0] touch_raw,
    input wire logic [6:0] touch_status,
    input wire logic [3:0] group_event_status,
    input wire logic [7:0] gpio_status,
    input wire logic [6:0] auto_cal_due,
    input wire logic slide_active,
    input wire logic analog_done,
    input wire logic digital_done,
    output tci_cal_out_type cal_out,
    output logic slide_repeat,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // address decode used by the read and write paths
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction : hit

    tci_state_type s_r;
    tci_state_type s_nxt;

    logic ms_tick;
    logic [NUM_SENSORS-1:0] sampled;
    logic grouped_touch;
    logic [13:0] press_limit;
    logic [13:0] repeat_limit;
    logic [NUM_SENSORS-1:0] manual_want;
    logic [NUM_SENSORS-1:0] want;
    logic [NUM_SENSORS-1:0] fail_now;
    logic [NUM_SENSORS-1:0] ok;
    logic [NUM_SENSORS-1:0] clr;
    logic clr_group;
    logic finish;
    logic timed_out;
    logic run_ok;
    logic group_in_mask;
    logic group_irq;
    logic touch_irq;
    logic gpio_irq;
    logic repeat_irq;

    ////////////////////////////////////////////////////////////////////////
    // millisecond prescaler and sampled sensor mask
    assign ms_tick = (s_r.ms_div == 32'(ms_cycles - 1));
    assign sampled = {group_sample_enable & {NUM_GROUPED{sample_enable[GROUP_BIT]}},
                      sample_enable[NUM_SINGLE-1:0]};
    assign grouped_touch = |(touch_raw[NUM_SENSORS-1:NUM_SINGLE] &
                             sampled[NUM_SENSORS-1:NUM_SINGLE]);
    assign press_limit = press_timeout_ms(s_r.group_timing[TIMEOUT_MSB:TIMEOUT_LSB]);
    assign repeat_limit = 14'((s_r.group_timing[REPEAT_MSB:REPEAT_LSB] + 5'd1) * REPEAT_STEP_MS);

    ////////////////////////////////////////////////////////////////////////
    // pending calibration requests
    always_comb begin
        manual_want = {s_r.group_cal_req, s_r.cal_request[NUM_SINGLE-1:0]};
        // group request covers all grouped sensors
        if (s_r.cal_request[GROUP_BIT]) begin
            manual_want[NUM_SENSORS-1:NUM_SINGLE] = {NUM_GROUPED{1'b1}};
        end
        // unsampled sensors keep their request until sampled
        want = (manual_want | s_r.auto_pend) & sampled;
    end
    // group bit may only clear in a run that holds grouped sensors
    assign group_in_mask = |want[NUM_SENSORS-1:NUM_SINGLE];

    ////////////////////////////////////////////////////////////////////////
    // sequencer completion terms
    // touch invalidates attempt
    assign fail_now = s_r.cal_fail | (s_r.cal.mask & touch_raw);
    // 600ms window bound
    // a run that overstays its window fails every sensor in it
    assign timed_out = ms_tick && (s_r.cal_ms == CAL_WINDOW_MS - 14'd1);
    assign finish = (s_r.cal_state == CAL_DIGITAL && digital_done) ||
                    (s_r.cal_state != CAL_IDLE && timed_out);
    // only a digital capture inside the window counts as success
    assign run_ok = (s_r.cal_state == CAL_DIGITAL) && digital_done && !timed_out;
    assign ok = run_ok ? s_r.cal.mask & ~fail_now : '0;
    assign clr = ok;
    // group clears only if every grouped sensor succeeded
    assign clr_group = finish && s_r.group_in_run &&
                       ((s_r.cal.mask[NUM_SENSORS-1:NUM_SINGLE] &
                         ~ok[NUM_SENSORS-1:NUM_SINGLE]) == '0);

    ////////////////////////////////////////////////////////////////////////
    // interrupt causes
    // group gesture gate
    assign group_irq = |group_event_status && s_r.touch_irq_en[GROUP_BIT];
    assign touch_irq = |(touch_status & s_r.touch_irq_en[NUM_SINGLE-1:0]);
    assign gpio_irq = |(gpio_status & s_r.gpio_irq_en);
    assign repeat_irq = s_r.repeat_pulse && s_r.touch_irq_en[GROUP_BIT];

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.cal.analog_start = 1'b0;
        s_nxt.cal.digital_start = 1'b0;
        s_nxt.repeat_pulse = 1'b0;
        s_nxt.press_done = 1'b0;
        s_nxt.ms_div = ms_tick ? 32'h0 : s_r.ms_div + 32'h1;

        s_nxt.cal_request[NUM_SINGLE-1:0] = s_r.cal_request[NUM_SINGLE-1:0] &
                                            ~clr[NUM_SINGLE-1:0];
        s_nxt.cal_request[GROUP_BIT] = s_r.cal_request[GROUP_BIT] & ~clr_group;
        s_nxt.group_cal_req = s_r.group_cal_req & ~clr[NUM_SENSORS-1:NUM_SINGLE];
        // pending auto requests survive failed runs
        s_nxt.auto_pend = s_r.auto_pend & ~clr;

        // register writes; request bits only set, so set wins over clear
        if (reg_write) begin
            if (hit(reg_addr, ADDR_GROUP_TIMING)) begin
                s_nxt.group_timing = reg_wdata;
            end
            if (hit(reg_addr, ADDR_AUTO_CAL_EN)) begin
                s_nxt.auto_cal_en = reg_wdata;
            end
            if (hit(reg_addr, ADDR_CAL_REQUEST)) begin
                s_nxt.cal_request = s_nxt.cal_request | reg_wdata;
            end
            if (hit(reg_addr, ADDR_TOUCH_IRQ_EN)) begin
                s_nxt.touch_irq_en = reg_wdata;
            end
            if (hit(reg_addr, ADDR_GPIO_IRQ_EN)) begin
                s_nxt.gpio_irq_en = reg_wdata;
            end
            if (hit(reg_addr, ADDR_GROUP_CAL_REQ)) begin
                s_nxt.group_cal_req = s_nxt.group_cal_req | reg_wdata[6:0];
            end
        end

        // reads return the value held before this edge's write
        // register reads, unmapped addresses read zero
        if (reg_read) begin
            case (1'b1)
                hit(reg_addr, ADDR_GROUP_TIMING): s_nxt.rdata = s_r.group_timing;
                hit(reg_addr, ADDR_AUTO_CAL_EN): s_nxt.rdata = s_r.auto_cal_en;
                hit(reg_addr, ADDR_CAL_REQUEST): s_nxt.rdata = s_r.cal_request;
                hit(reg_addr, ADDR_TOUCH_IRQ_EN): s_nxt.rdata = s_r.touch_irq_en;
                hit(reg_addr, ADDR_GPIO_IRQ_EN): s_nxt.rdata = s_r.gpio_irq_en;
                hit(reg_addr, ADDR_GROUP_CAL_REQ): s_nxt.rdata = {1'b0, s_r.group_cal_req};
                default: s_nxt.rdata = 8'h00;
            endcase
        end

        // timer stops at its limit, so one press fires once
        // grouped press duration timer
        if (!grouped_touch) begin
            s_nxt.press_ms = 14'd0;
        end else if (ms_tick && s_r.press_ms < press_limit) begin
            s_nxt.press_ms = s_r.press_ms + 14'd1;
            s_nxt.press_done = (s_r.press_ms == press_limit - 14'd1);
        end

        // free-running ms tick: first repeat may come up to 1ms early
        // slide auto repeat timer
        if (!slide_active) begin
            s_nxt.repeat_ms = 14'd0;
        end else if (ms_tick) begin
            if (s_r.repeat_ms >= repeat_limit - 14'd1) begin
                s_nxt.repeat_ms = 14'd0;
                s_nxt.repeat_pulse = 1'b1;
            end else begin
                s_nxt.repeat_ms = s_r.repeat_ms + 14'd1;
            end
        end

        // auto requests only for sampled sensors
        s_nxt.auto_pend[NUM_SINGLE-1:0] = s_nxt.auto_pend[NUM_SINGLE-1:0] |
            (auto_cal_due & s_r.auto_cal_en[NUM_SINGLE-1:0] & sampled[NUM_SINGLE-1:0]);
        // group auto recal needs group enable
        if (s_r.press_done && s_r.auto_cal_en[GROUP_BIT]) begin
            s_nxt.auto_pend[NUM_SENSORS-1:NUM_SINGLE] =
                s_nxt.auto_pend[NUM_SENSORS-1:NUM_SINGLE] | sampled[NUM_SENSORS-1:NUM_SINGLE];
        end

        // recalibration sequencer
        // requests raised while busy wait for the next run
        if (s_r.cal_state != CAL_IDLE && ms_tick) begin
            s_nxt.cal_ms = s_r.cal_ms + 14'd1;
        end
        if (s_r.cal_state != CAL_IDLE) begin
            s_nxt.cal_fail = fail_now;
        end
        case (s_r.cal_state)
            CAL_IDLE: begin
                if (|want) begin
                    s_nxt.cal.mask = want;
                    s_nxt.cal.busy = 1'b1;
                    s_nxt.cal.analog_start = 1'b1;
                    s_nxt.cal_fail = '0;
                    s_nxt.cal_ms = 14'd0;
                    s_nxt.group_in_run = s_r.cal_request[GROUP_BIT] && group_in_mask;
                    s_nxt.cal_state = CAL_ANALOG;
                end
            end
            CAL_ANALOG: begin
                if (timed_out) begin
                    s_nxt.cal_state = CAL_IDLE;
                end else if (analog_done) begin
                    s_nxt.cal.digital_start = 1'b1;
                    s_nxt.cal_state = CAL_DIGITAL;
                end
            end
            CAL_DIGITAL: begin
                if (finish) begin
                    s_nxt.cal_state = CAL_IDLE;
                end
            end
            default: begin
                s_nxt.cal_state = CAL_IDLE;
            end
        endcase
        // a timed-out analog phase ends the run as well
        if (finish || (s_r.cal_state == CAL_ANALOG && timed_out)) begin
            s_nxt.cal.mask = '0;
            s_nxt.cal.busy = 1'b0;
            s_nxt.group_in_run = 1'b0;
        end

        // registered interrupt pin
        s_nxt.irq = group_irq || touch_irq || gpio_irq || repeat_irq;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clock) begin
        if (rst) begin
            s_r <= '0;
            s_r.group_timing <= RST_GROUP_TIMING;
            s_r.auto_cal_en <= RST_AUTO_CAL_EN;
            s_r.cal_request <= RST_CAL_REQUEST;
            s_r.touch_irq_en <= RST_TOUCH_IRQ_EN;
            s_r.gpio_irq_en <= RST_GPIO_IRQ_EN;
            s_r.group_cal_req <= RST_GROUP_CAL_REQ;
            s_r.cal_state <= CAL_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign reg_rdata = s_r.rdata;
    // mask blanks presses and base counts
    assign cal_out = s_r.cal;
    assign slide_repeat = s_r.repeat_pulse;
    assign irq = s_r.irq;

endmodule : tci_regs

// >>> tb/tci_regs_properties.sv
// tci_regs_properties: port checks of the calibration and interrupt bank.
// assumes a bind onto tci_regs; rst is synchronous, active high.
`timescale 1ns/1ps
module tci_regs_properties
    import tci_pkg::*;
#(
    parameter int ms_cycles = MS_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] sample_enable,
    input wire logic [6:0] group_sample_enable,
    input wire logic [6:0] touch_status,
    input wire logic [3:0] group_event_status,
    input wire logic [7:0] gpio_status,
    input wire logic slide_active,
    input wire logic analog_done,
    input wire tci_cal_out_type cal_out,
    input wire logic slide_repeat,
    input wire logic irq
);
    localparam int cal_limit = 601 * ms_cycles + 4;
    logic [31:0] busy_cnt_r;
    logic quiet;
    logic [13:0] sampled;
    assign quiet = !slide_active && touch_status == 7'h00 && group_event_status == 4'h0
        && gpio_status == 8'h00;
    assign sampled = {group_sample_enable & {7{sample_enable[7]}}, sample_enable[6:0]};
    always_ff @(posedge clock) begin
        if (rst || cal_out.analog_start || !cal_out.busy) begin
            busy_cnt_r <= 32'h0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 32'h1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    chk_spare_bit_zero: assert property (
        reg_read && reg_addr == ADDR_GROUP_CAL_REQ |=> !reg_rdata[7])
        else $error("spare request bit reads one");
    chk_irq_quiet: assert property (
        quiet [*3] |=> !irq)
        else $error("irq without a cause");
    chk_start_busy: assert property (
        cal_out.analog_start |-> cal_out.busy ##1 !cal_out.analog_start)
        else $error("analog start not a busy pulse");
    chk_digital_after: assert property (
        cal_out.digital_start |-> $past(analog_done) && cal_out.busy)
        else $error("digital start without analog done");
    chk_busy_mask: assert property (
        cal_out.busy |-> cal_out.mask != 14'h0)
        else $error("busy with empty mask");
    chk_mask_sampled: assert property (
        cal_out.analog_start |-> (cal_out.mask & ~$past(sampled)) == 14'h0)
        else $error("unsampled sensor launched");
    chk_cal_window: assert property (
        busy_cnt_r <= cal_limit)
        else $error("recalibration outlives its window");
    chk_repeat_slide: assert property (
        slide_repeat |-> $past(slide_active))
        else $error("repeat pulse without slide");
    cover property (cal_out.analog_start);
    cover property (cal_out.digital_start);
    cover property (slide_repeat);
endmodule : tci_regs_properties

// >>> tb/tci_cal_engine.sv
// tci_cal_engine: sensing engine stand-in answering the two calibration phases.
// assumes one-cycle start pulses and a delay of at least one cycle.
`timescale 1ns/1ps
module tci_cal_engine
    import tci_pkg::*;
(
    input wire logic clock,
    input wire tci_cal_out_type cal_out,
    input wire logic [7:0] delay,
    output logic analog_done,
    output logic digital_done
);
    initial begin
        analog_done = 1'b0;
        digital_done = 1'b0;
    end
    always @(posedge clock) begin
        if (cal_out.analog_start === 1'b1) begin
            repeat (delay) @(negedge clock);
            analog_done <= 1'b1;
            @(negedge clock);
            analog_done <= 1'b0;
        end else if (cal_out.digital_start === 1'b1) begin
            repeat (delay) @(negedge clock);
            digital_done <= 1'b1;
            @(negedge clock);
            digital_done <= 1'b0;
        end
    end
endmodule : tci_cal_engine

// >>> tb/testbench.sv
// testbench: drives tci_regs through its register port and status inputs.
// assumes tci_cal_engine answers the calibration phases.
`timescale 1ns/1ps
module testbench;
    import tci_pkg::*;
    localparam int msc = 10;
    localparam logic [7:0] rw_addr [4] = '{8'h24, 8'h25, 8'h27, 8'h28};
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] sample_enable = 8'hff;
    logic [6:0] group_sample_enable = 7'h7f;
    logic [13:0] touch_raw = 14'h0;
    logic [6:0] touch_status = 7'h0;
    logic [3:0] group_event_status = 4'h0;
    logic [7:0] gpio_status = 8'h0;
    logic [6:0] auto_cal_due = 7'h0;
    logic slide_active = 1'b0;
    logic [7:0] cal_delay = 8'd20;
    logic [7:0] reg_rdata;
    logic analog_done;
    logic digital_done;
    logic slide_repeat;
    logic irq;
    tci_cal_out_type cal_out;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    int starts = 0;
    int s0;
    logic [31:0] seed = 32'hca98;
    always #2.5 clock = ~clock;
    tci_regs #(.ms_cycles(msc)) dut_u (.clock(clock), .rst(rst), .reg_write(reg_write),
        .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .sample_enable(sample_enable),
        .group_sample_enable(group_sample_enable), .touch_raw(touch_raw),
        .touch_status(touch_status), .group_event_status(group_event_status),
        .gpio_status(gpio_status), .auto_cal_due(auto_cal_due), .slide_active(slide_active),
        .analog_done(analog_done), .digital_done(digital_done), .cal_out(cal_out),
        .slide_repeat(slide_repeat), .irq(irq));
    tci_cal_engine eng_u (.clock(clock), .cal_out(cal_out), .delay(cal_delay),
        .analog_done(analog_done), .digital_done(digital_done));
    always @(posedge clock) begin
        cycles++;
        if (cal_out.analog_start === 1'b1) starts++;
        if (cycles == 60000) begin
            failures++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_write = 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        reg_read = 1'b1;
        reg_addr = a;
        @(negedge clock);
        reg_read = 1'b0;
        chk("rdata", {6'h0, exp}, {6'h0, reg_rdata});
    endtask : rdc
    task automatic wait_idle();
        for (int k = 0; k < 2; k++) begin
            for (int n = 0; n < 5000 && cal_out.busy !== 1'b0; n++) tick(1);
            tick(4);
        end
    endtask : wait_idle
    task automatic run_cal(input logic [7:0] a, input logic [7:0] d, input logic [13:0] m,
        input logic tch);
        wr(a, d);
        tick(3);
        chk("mask", m, cal_out.mask);
        touch_raw = tch ? m : 14'h0;
        tick(2);
        touch_raw = 14'h0;
        wait_idle();
        rdc(a, 8'h00);
    endtask : run_cal
    task automatic irq_chk(input logic [7:0] a, input logic [7:0] d, input logic exp);
        wr(a, d);
        tick(3);
        chk("irq", {13'h0, exp}, {13'h0, irq});
    endtask : irq_chk
    task automatic slide_gap(input logic [3:0] code, input logic gate);
        int n;
        wr(ADDR_GROUP_TIMING, {4'hd, code});
        wr(ADDR_TOUCH_IRQ_EN, gate ? 8'h80 : 8'h7f);
        slide_active = 1'b1;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                tick(1);
                n++;
            end while (slide_repeat !== 1'b1 && n < 3000);
        end
        chk("repeat gap", 14'((code + 1) * 35 * msc), 14'(n));
        tick(1);
        chk("repeat irq", {13'h0, gate}, {13'h0, irq});
        slide_active = 1'b0;
    endtask : slide_gap
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(8);
        rst = 1'b0;
        rdc(ADDR_GROUP_TIMING, RST_GROUP_TIMING);
        rdc(ADDR_AUTO_CAL_EN, RST_AUTO_CAL_EN);
        rdc(ADDR_CAL_REQUEST, RST_CAL_REQUEST);
        rdc(ADDR_TOUCH_IRQ_EN, RST_TOUCH_IRQ_EN);
        rdc(ADDR_GPIO_IRQ_EN, RST_GPIO_IRQ_EN);
        rdc(ADDR_GROUP_CAL_REQ, 8'h00);
        rdc(8'h30, 8'h00);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr(rw_addr[i], seed[7:0]);
            rdc(rw_addr[i], seed[7:0]);
        end
        $display("test registers done");
        run_cal(ADDR_CAL_REQUEST, 8'h01, 14'h0001, 1'b0);
        run_cal(ADDR_CAL_REQUEST, 8'h80, 14'h3f80, 1'b0);
        run_cal(ADDR_GROUP_CAL_REQ, 8'h40, 14'h2000, 1'b0);
        s0 = starts;
        run_cal(ADDR_CAL_REQUEST, 8'h04, 14'h0004, 1'b1);
        chk("restart", 14'h1, 14'(starts - s0 > 1));
        wr(ADDR_CAL_REQUEST, 8'h00);
        tick(3);
        chk("busy", 14'h0, {13'h0, cal_out.busy});
        sample_enable = 8'hfd;
        wr(ADDR_CAL_REQUEST, 8'h02);
        tick(4);
        chk("busy", 14'h0, {13'h0, cal_out.busy});
        rdc(ADDR_CAL_REQUEST, 8'h02);
        sample_enable = 8'hff;
        run_cal(ADDR_CAL_REQUEST, 8'h02, 14'h0002, 1'b0);
        $display("test calibration done");
        gpio_status = 8'h01;
        irq_chk(ADDR_GPIO_IRQ_EN, 8'h00, 1'b0);
        irq_chk(ADDR_GPIO_IRQ_EN, 8'h01, 1'b1);
        gpio_status = 8'h00;
        touch_status = 7'h40;
        irq_chk(ADDR_TOUCH_IRQ_EN, 8'hff, 1'b1);
        irq_chk(ADDR_TOUCH_IRQ_EN, 8'h80, 1'b0);
        touch_status = 7'h00;
        group_event_status = 4'h8;
        irq_chk(ADDR_TOUCH_IRQ_EN, 8'h80, 1'b1);
        irq_chk(ADDR_TOUCH_IRQ_EN, 8'h7f, 1'b0);
        group_event_status = 4'h0;
        $display("test interrupts done");
        slide_gap(4'h0, 1'b1);
        slide_gap(4'h4, 1'b0);
        $display("test repeat done");
        wr(ADDR_AUTO_CAL_EN, 8'hff);
        auto_cal_due = 7'h08;
        tick(1);
        auto_cal_due = 7'h00;
        tick(3);
        chk("mask", 14'h0008, cal_out.mask);
        wait_idle();
        wr(ADDR_AUTO_CAL_EN, 8'hf7);
        auto_cal_due = 7'h08;
        tick(1);
        auto_cal_due = 7'h00;
        tick(4);
        chk("busy", 14'h0, {13'h0, cal_out.busy});
        $display("test auto done");
        wr(ADDR_GROUP_TIMING, 8'h04);
        wr(ADDR_AUTO_CAL_EN, 8'h7f);
        touch_raw = 14'h0080;
        tick(560 * msc + 10);
        chk("busy", 14'h0, {13'h0, cal_out.busy});
        touch_raw = 14'h0;
        wr(ADDR_AUTO_CAL_EN, 8'hff);
        touch_raw = 14'h0080;
        tick(560 * msc - 20);
        chk("busy", 14'h0, {13'h0, cal_out.busy});
        tick(30);
        chk("mask", 14'h3f80, cal_out.mask);
        touch_raw = 14'h0;
        wait_idle();
        $display("test press done");
        finish_test();
    end
endmodule : testbench

bind tci_regs tci_regs_properties #(.ms_cycles(ms_cycles)) chk_u (.clock(clock), .rst(rst),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .sample_enable(sample_enable), .group_sample_enable(group_sample_enable),
    .touch_status(touch_status), .group_event_status(group_event_status),
    .gpio_status(gpio_status), .slide_active(slide_active), .analog_done(analog_done),
    .cal_out(cal_out), .slide_repeat(slide_repeat), .irq(irq));
